// ### design/c15_access_check.sv
// Decode and permission check for one coprocessor transfer.
// Assumes security and mode inputs are valid in the cycle of the request.
`timescale 1ns/1ps
`default_nettype none
module c15_access_check (
  input  wire logic       isWrite,
  input  wire logic [2:0] op1,
  input  wire logic [3:0] crn,
  input  wire logic [3:0] crm,
  input  wire logic [2:0] op2,
  input  wire logic       nonsecure,
  input  wire logic       userMode,
  output c15_regs_pkg::enc_t enc,
  output logic            denied,
  output logic            update
);

  // Denied answers undefined; update says whether a write may change state
  always_comb begin
    enc    = c15_regs_pkg::decodeEnc(op1, crn, crm, op2);
    denied = 1'b1;
    update = 1'b0;
    case (enc)
      c15_regs_pkg::ENC_VBUSY: begin
        denied = 1'b0;
        update = 1'b0;
      end
      c15_regs_pkg::ENC_CFGBASE: begin
        denied = 1'b0;
        update = isWrite && !nonsecure && !userMode;
      end
      c15_regs_pkg::ENC_SEL_RD, c15_regs_pkg::ENC_SEL_WR: begin
        denied = nonsecure || userMode || !isWrite;
        update = !denied;
      end
      c15_regs_pkg::ENC_VTAG, c15_regs_pkg::ENC_PADDR: begin
        denied = nonsecure || userMode;
        update = !denied && isWrite;
      end
      c15_regs_pkg::ENC_ATTR: begin
        denied = userMode;
        update = !denied && isWrite;
      end
      default: begin
        denied = 1'b1;
        update = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// ### design/c15_regs_pkg.sv
// Constants, encodings and types shared by the c15 register group.
// Assumes a coprocessor transfer port that presents op1, CRn, CRm and op2.
package c15_regs_pkg;

  // ****************************************************************
  // Widths and build values
  // ****************************************************************
  localparam int           DATA_W       = 32;
  localparam int           LOCK_ENTRIES = 4;
  localparam int           LOCK_IDX_W   = 2;
  localparam logic [2:0]   STRAP_SETTLE = 3'h4;

  // ****************************************************************
  // Coprocessor encodings (CRn is always c15)
  // ****************************************************************
  localparam logic [3:0]   CRN_C15      = 4'hf;
  localparam logic [2:0]   OP1_VBUSY    = 3'h0;
  localparam logic [3:0]   CRM_VBUSY    = 4'h1;
  localparam logic [2:0]   OP2_VBUSY    = 3'h0;
  localparam logic [2:0]   OP1_CFGBASE  = 3'h4;
  localparam logic [3:0]   CRM_CFGBASE  = 4'h0;
  localparam logic [2:0]   OP2_CFGBASE  = 3'h0;
  localparam logic [2:0]   OP1_LOCK     = 3'h5;
  localparam logic [3:0]   CRM_SELECT   = 4'h4;
  localparam logic [2:0]   OP2_SEL_RD   = 3'h2;
  localparam logic [2:0]   OP2_SEL_WR   = 3'h4;
  localparam logic [3:0]   CRM_VTAG     = 4'h5;
  localparam logic [3:0]   CRM_PADDR    = 4'h6;
  localparam logic [3:0]   CRM_ATTR     = 4'h7;
  localparam logic [2:0]   OP2_LOCKDATA = 3'h2;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int           VBUSY_BIT    = 0;
  localparam int           CFG_BASE_LSB = 13;
  localparam int           CFG_BASE_W   = 19;
  localparam int           VPN_LSB      = 12;
  localparam int           NSTAG_BIT    = 10;
  localparam int           SPACE_ID_W   = 10;
  localparam logic [31:0]  VTAG_WMASK   = 32'hfffff7ff;
  localparam logic [31:0]  VBUSY_RESET  = 32'h00000000;
  localparam logic [18:0]  CFG_RESET    = 19'h00000;
  localparam logic [31:0]  LOCK_RESET   = 32'h00000000;

  typedef enum logic [2:0] {
    ENC_NONE    = 3'h0,
    ENC_VBUSY   = 3'h1,
    ENC_CFGBASE = 3'h2,
    ENC_SEL_RD  = 3'h3,
    ENC_SEL_WR  = 3'h4,
    ENC_VTAG    = 3'h5,
    ENC_PADDR   = 3'h6,
    ENC_ATTR    = 3'h7
  } enc_t;

  typedef enum logic {
    PH_STRAP = 1'b0,
    PH_RUN   = 1'b1
  } phase_t;

  // Maps a transfer encoding onto one register of this group
  function automatic enc_t decodeEnc(input logic [2:0] op1, input logic [3:0] crn,
                                     input logic [3:0] crm, input logic [2:0] op2);
    enc_t e;
    e = ENC_NONE;
    if (crn != CRN_C15) begin
      e = ENC_NONE;
    end else if (op1 == OP1_VBUSY && crm == CRM_VBUSY && op2 == OP2_VBUSY) begin
      e = ENC_VBUSY;
    end else if (op1 == OP1_CFGBASE && crm == CRM_CFGBASE && op2 == OP2_CFGBASE) begin
      e = ENC_CFGBASE;
    end else if (op1 == OP1_LOCK && crm == CRM_SELECT && op2 == OP2_SEL_RD) begin
      e = ENC_SEL_RD;
    end else if (op1 == OP1_LOCK && crm == CRM_SELECT && op2 == OP2_SEL_WR) begin
      e = ENC_SEL_WR;
    end else if (op1 == OP1_LOCK && crm == CRM_VTAG && op2 == OP2_LOCKDATA) begin
      e = ENC_VTAG;
    end else if (op1 == OP1_LOCK && crm == CRM_PADDR && op2 == OP2_LOCKDATA) begin
      e = ENC_PADDR;
    end else if (op1 == OP1_LOCK && crm == CRM_ATTR && op2 == OP2_LOCKDATA) begin
      e = ENC_ATTR;
    end
    return e;
  endfunction

endpackage

// ### design/strap_sync.sv
// Three-stage synchroniser for a static strap bus.
// Assumes the strap is quasi-static; the output moves once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module strap_sync #(
  parameter int W = 19
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } sync_t;

  sync_t st;
  sync_t nx;

  // Stage one feeds stage two only; agreement filters a mid-change sample
  always_comb begin
    nx    = st;
    nx.s1 = pinIn;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    if (st.s2 == st.s3) begin
      nx.stable = st.s3;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign syncOut = st.stable;

endmodule
`default_nettype wire

// ### design/tlb_lockdown_c15_regs.sv
// Implementation-specific c15 register group of the core: vector busy status,
// configuration base address and the locked main TLB entry save/restore path.
// Assumes one transfer request per cycle at most, answered on the next edge.
`timescale 1ns/1ps
`default_nettype none

module tlb_lockdown_c15_regs #(
  parameter bit MULTI_CORE = 1'b1
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic [2:0]  reqOp1,
  input  wire logic [3:0]  reqCrn,
  input  wire logic [3:0]  reqCrm,
  input  wire logic [2:0]  reqOp2,
  input  wire logic [31:0] reqWdata,
  input  wire logic        nonsecure,
  input  wire logic        userMode,
  input  wire logic        vecPipeBusy,
  input  wire logic        coreVecBusy,
  input  wire logic [31:13] peripheralBaseStrap,
  output logic             respValid,
  output logic             respDenied,
  output logic [31:0]      respData,
  output logic [31:13]     cfgBaseOut
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    c15_regs_pkg::phase_t phase;
    logic [2:0]                                 settle;
    logic [c15_regs_pkg::CFG_BASE_W-1:0]        cfgBase;
    logic [c15_regs_pkg::LOCK_IDX_W-1:0]        rdIdx;
    logic [c15_regs_pkg::LOCK_IDX_W-1:0]        wrIdx;
    logic [31:0]                                stageVtag;
    logic [31:0]                                stageAttr;
    logic [c15_regs_pkg::LOCK_ENTRIES-1:0][31:0] vtag;
    logic [c15_regs_pkg::LOCK_ENTRIES-1:0][31:0] paddr;
    logic [c15_regs_pkg::LOCK_ENTRIES-1:0][31:0] attr;
    logic                                       respValid;
    logic                                       respDenied;
    logic [31:0]                                respData;
  } state_t;

  state_t st;
  state_t nx;

  logic [c15_regs_pkg::CFG_BASE_W-1:0] strapSync;
  c15_regs_pkg::enc_t                 enc;
  logic                               denied;
  logic                               update;
  logic                               vecBusy;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Strap comes from outside the clock domain
  strap_sync #(
    .W (c15_regs_pkg::CFG_BASE_W)
  ) u_strap_sync (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .pinIn   (peripheralBaseStrap),
    .syncOut (strapSync)
  );

  c15_access_check u_access_check (
    .isWrite   (reqWrite),
    .op1       (reqOp1),
    .crn       (reqCrn),
    .crm       (reqCrm),
    .op2       (reqOp2),
    .nonsecure (nonsecure),
    .userMode  (userMode),
    .enc       (enc),
    .denied    (denied),
    .update    (update)
  );

  // Busy from either pipeline; both sources run on mclk, so no sync
  assign vecBusy = vecPipeBusy || coreVecBusy;

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Strap load after reset release, then one transfer per request
  always_comb begin
    nx            = st;
    nx.respValid  = 1'b0;
    nx.respDenied = 1'b0;
    case (st.phase)
      c15_regs_pkg::PH_STRAP: begin
        // Strap is followed until the synchroniser has settled
        if (MULTI_CORE) begin
          nx.cfgBase = strapSync;
        end else begin
          nx.cfgBase = c15_regs_pkg::CFG_RESET;
        end
        // Last load must see the synchroniser output that moved at the fourth edge
        nx.settle = st.settle + 3'h1;
        if (st.settle == c15_regs_pkg::STRAP_SETTLE) begin
          nx.phase = c15_regs_pkg::PH_RUN;
        end
      end
      default: begin
        nx.phase = c15_regs_pkg::PH_RUN;
      end
    endcase

    if (reqValid) begin
      nx.respValid  = 1'b1;
      nx.respDenied = denied;
      nx.respData   = 32'h00000000;
      if (!denied && !reqWrite) begin
        // Read path
        case (enc)
          c15_regs_pkg::ENC_VBUSY: begin
            nx.respData[c15_regs_pkg::VBUSY_BIT] = vecBusy;
          end
          c15_regs_pkg::ENC_CFGBASE: begin
            nx.respData[31:c15_regs_pkg::CFG_BASE_LSB] = st.cfgBase;
          end
          c15_regs_pkg::ENC_VTAG: begin
            nx.respData = st.vtag[st.rdIdx];
          end
          c15_regs_pkg::ENC_PADDR: begin
            nx.respData = st.paddr[st.rdIdx];
          end
          c15_regs_pkg::ENC_ATTR: begin
            nx.respData = st.attr[st.rdIdx];
          end
          default: begin
            nx.respData = 32'h00000000;
          end
        endcase
      end else if (!denied && update) begin
        // Write path; vector busy and guarded base writes never get here
        case (enc)
          c15_regs_pkg::ENC_CFGBASE: begin
            nx.cfgBase = reqWdata[31:c15_regs_pkg::CFG_BASE_LSB];
          end
          c15_regs_pkg::ENC_SEL_RD: begin
            nx.rdIdx = reqWdata[c15_regs_pkg::LOCK_IDX_W-1:0];
          end
          c15_regs_pkg::ENC_SEL_WR: begin
            nx.wrIdx = reqWdata[c15_regs_pkg::LOCK_IDX_W-1:0];
          end
          c15_regs_pkg::ENC_VTAG: begin
            // Bit 11 is kept zero; page, tag and space id are stored
            nx.stageVtag = reqWdata & c15_regs_pkg::VTAG_WMASK;
          end
          c15_regs_pkg::ENC_ATTR: begin
            nx.stageAttr = reqWdata;
          end
          c15_regs_pkg::ENC_PADDR: begin
            // Entry is committed as a whole so a half-restored entry is never live
            nx.paddr[st.wrIdx] = reqWdata;
            nx.vtag[st.wrIdx]  = st.stageVtag;
            nx.attr[st.wrIdx]  = st.stageAttr;
          end
          default: begin
            nx.respData = 32'h00000000;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************

  // Reset values are constants only; the strap is caught after release
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st.phase      <= c15_regs_pkg::PH_STRAP;
      st.settle     <= 3'h0;
      st.cfgBase    <= c15_regs_pkg::CFG_RESET;
      st.rdIdx      <= '0;
      st.wrIdx      <= '0;
      st.stageVtag  <= c15_regs_pkg::LOCK_RESET;
      st.stageAttr  <= c15_regs_pkg::LOCK_RESET;
      st.vtag       <= '0;
      st.paddr      <= '0;
      st.attr       <= '0;
      st.respValid  <= 1'b0;
      st.respDenied <= 1'b0;
      st.respData   <= c15_regs_pkg::VBUSY_RESET;
    end else begin
      st <= nx;
    end
  end

  assign respValid  = st.respValid;
  assign respDenied = st.respDenied;
  assign respData   = st.respData;
  assign cfgBaseOut = st.cfgBase;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence busyRead;
    reqValid && !reqWrite && enc == c15_regs_pkg::ENC_VBUSY;
  endsequence

  sequence busyWrite;
    reqValid && reqWrite && enc == c15_regs_pkg::ENC_VBUSY;
  endsequence

  sequence baseWrite;
    reqValid && reqWrite && enc == c15_regs_pkg::ENC_CFGBASE && st.phase == c15_regs_pkg::PH_RUN;
  endsequence

  sequence lockAccess;
    reqValid && (enc == c15_regs_pkg::ENC_SEL_RD || enc == c15_regs_pkg::ENC_SEL_WR ||
                 enc == c15_regs_pkg::ENC_VTAG || enc == c15_regs_pkg::ENC_PADDR);
  endsequence

  busy_value_a: assert property (busyRead |=> respValid && !respDenied &&
                                 respData == {31'h00000000, $past(vecBusy)})
    else $error("busy read value wrong");

  busy_write_a: assert property (busyWrite |=> respValid && !respDenied && respData == 32'h00000000)
    else $error("busy write had effect");

  base_secure_a: assert property (baseWrite and (!nonsecure && !userMode) |=>
                                  cfgBaseOut == $past(reqWdata[31:13]))
    else $error("secure base write lost");

  base_nonsec_a: assert property (baseWrite and nonsecure |=> $stable(cfgBaseOut) && !respDenied)
    else $error("non-secure base write took effect");

  base_user_a: assert property (baseWrite and userMode |=> $stable(cfgBaseOut))
    else $error("user base write took effect");

  base_strap_a: assert property (st.phase == c15_regs_pkg::PH_STRAP ##1 st.phase == c15_regs_pkg::PH_STRAP
                                 |-> cfgBaseOut == (MULTI_CORE ? $past(strapSync) : c15_regs_pkg::CFG_RESET))
    else $error("base not loaded from strap");

  lock_deny_a: assert property (lockAccess and nonsecure |=> respValid && respDenied)
    else $error("non-secure lockdown access allowed");

  read_select_a: assert property (reqValid && !reqWrite && !denied && enc == c15_regs_pkg::ENC_VTAG
                                  |=> respData == $past(st.vtag[st.rdIdx]))
    else $error("virtual tag read from wrong entry");

  commit_entry_a: assert property (reqValid && reqWrite && !denied && enc == c15_regs_pkg::ENC_PADDR
                                   |=> st.paddr[$past(st.wrIdx)] == $past(reqWdata) &&
                                       st.vtag[$past(st.wrIdx)] == $past(st.stageVtag))
    else $error("lockdown entry not committed");

  vtag_mask_a: assert property (reqValid && reqWrite && !denied && enc == c15_regs_pkg::ENC_VTAG
                                |=> st.stageVtag[11] == 1'b0 && st.stageVtag[10:0] == $past(reqWdata[10:0]))
    else $error("virtual tag layout wrong");

  // Every request gets exactly one answer on the next edge
  answer_timing_a: assert property (reqValid |=> respValid)
    else $error("request not answered");

  answer_quiet_a: assert property (!reqValid |=> !respValid)
    else $error("answer without request");

  // Selects are write-only operations
  select_read_a: assert property (reqValid && !reqWrite &&
                                  (enc == c15_regs_pkg::ENC_SEL_RD || enc == c15_regs_pkg::ENC_SEL_WR)
                                  |=> respDenied)
    else $error("select read not refused");

  read_index_a: assert property (reqValid && reqWrite && !denied && enc == c15_regs_pkg::ENC_SEL_RD
                                 |=> st.rdIdx == $past(reqWdata[c15_regs_pkg::LOCK_IDX_W-1:0]))
    else $error("read index not taken");

  write_index_a: assert property (reqValid && reqWrite && !denied && enc == c15_regs_pkg::ENC_SEL_WR
                                  |=> st.wrIdx == $past(reqWdata[c15_regs_pkg::LOCK_IDX_W-1:0]))
    else $error("write index not taken");

  paddr_read_a: assert property (reqValid && !reqWrite && !denied && enc == c15_regs_pkg::ENC_PADDR
                                 |=> respData == $past(st.paddr[st.rdIdx]))
    else $error("physical address read from wrong entry");

  attr_read_a: assert property (reqValid && !reqWrite && !denied && enc == c15_regs_pkg::ENC_ATTR
                                |=> respData == $past(st.attr[st.rdIdx]))
    else $error("attribute read from wrong entry");

  // Lockdown is privileged only, attribute access included
  attr_user_a: assert property (reqValid && userMode && enc == c15_regs_pkg::ENC_ATTR |=> respDenied)
    else $error("user attribute access allowed");

  // Base reads are open to every state and mode
  base_read_a: assert property (reqValid && !reqWrite && enc == c15_regs_pkg::ENC_CFGBASE
                                |=> !respDenied && respData == {$past(st.cfgBase), 13'h0000})
    else $error("base read value wrong");

endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the c15 register group: busy status, base address
// and locked entry save/restore. Assumes the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ************************************************************
  // Stimulus signals
  // ************************************************************
  logic        mclk;
  logic        rst_b;
  logic        reqValid;
  logic        reqWrite;
  logic [2:0]  reqOp1;
  logic [3:0]  reqCrn;
  logic [3:0]  reqCrm;
  logic [2:0]  reqOp2;
  logic [31:0] reqWdata;
  logic        nonsecure;
  logic        userMode;
  logic        vecPipeBusy;
  logic        coreVecBusy;
  logic [31:13] peripheralBaseStrap;
  logic        respValid;
  logic        respDenied;
  logic [31:0] respData;
  logic [31:13] cfgBaseOut;
  logic [31:13] cfgBaseSingle;
  int          errors;
  int          n_tests;
  logic [31:0] gotData;
  logic        gotDen;

  // Multi-core build under test, single-core build only watched for its base
  tlb_lockdown_c15_regs #(.MULTI_CORE(1'b1)) tlb_lockdown_c15_regs_i (
    .mclk(mclk), .rst_b(rst_b), .reqValid(reqValid), .reqWrite(reqWrite), .reqOp1(reqOp1),
    .reqCrn(reqCrn), .reqCrm(reqCrm), .reqOp2(reqOp2), .reqWdata(reqWdata), .nonsecure(nonsecure),
    .userMode(userMode), .vecPipeBusy(vecPipeBusy), .coreVecBusy(coreVecBusy),
    .peripheralBaseStrap(peripheralBaseStrap), .respValid(respValid), .respDenied(respDenied),
    .respData(respData), .cfgBaseOut(cfgBaseOut));
  tlb_lockdown_c15_regs #(.MULTI_CORE(1'b0)) single_core_i (
    .mclk(mclk), .rst_b(rst_b), .reqValid(reqValid), .reqWrite(reqWrite), .reqOp1(reqOp1),
    .reqCrn(reqCrn), .reqCrm(reqCrm), .reqOp2(reqOp2), .reqWdata(reqWdata), .nonsecure(nonsecure),
    .userMode(userMode), .vecPipeBusy(vecPipeBusy), .coreVecBusy(coreVecBusy),
    .peripheralBaseStrap(peripheralBaseStrap), .respValid(), .respDenied(),
    .respData(), .cfgBaseOut(cfgBaseSingle));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One transfer: raised at a falling edge, taken at the rising edge, answer read a cycle later
  task automatic xfer(input logic wr, input logic [2:0] op1, input logic [3:0] crm, input logic [2:0] op2,
                      input logic [31:0] wd, input logic ns, input logic usr);
    @(negedge mclk);
    reqValid = 1'b1;
    reqWrite = wr;
    reqOp1 = op1;
    reqCrm = crm;
    reqOp2 = op2;
    reqWdata = wd;
    nonsecure = ns;
    userMode = usr;
    @(negedge mclk);
    reqValid = 1'b0;
    chk({31'h0, respValid}, 32'h1);
    gotData = respData;
    gotDen = respDenied;
  endtask

  // Transfer plus check of data and denial
  task automatic acc(input logic wr, input logic [2:0] op1, input logic [3:0] crm, input logic [2:0] op2,
                     input logic [31:0] wd, input logic ns, input logic usr, input logic [31:0] expD,
                     input logic expN);
    xfer(wr, op1, crm, op2, wd, ns, usr);
    chk(gotData, expD);
    chk({31'h0, gotDen}, {31'h0, expN});
  endtask

  // Patterns per entry; bit 11 of the tag pattern is set to see it cleared
  function automatic logic [31:0] vtPat(input int i);
    return 32'ha5a5_5fff ^ (i << 24);
  endfunction
  function automatic logic [31:0] atPat(input int i);
    return 32'h0000_0abc + i;
  endfunction
  function automatic logic [31:0] paPat(input int i);
    return 32'h1234_5001 + (i << 12);
  endfunction

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_reset();
    chk({13'h0, cfgBaseOut}, {13'h0, peripheralBaseStrap});
    chk({13'h0, cfgBaseSingle}, 32'h0);
    acc(1'b0, c15_regs_pkg::OP1_VBUSY, c15_regs_pkg::CRM_VBUSY, c15_regs_pkg::OP2_VBUSY, 32'h0, 1'b0, 1'b0,
        c15_regs_pkg::VBUSY_RESET, 1'b0);
    $display("test reset done");
  endtask

  task automatic test_busy();
    for (int k = 0; k < 4; k++) begin
      vecPipeBusy = k[0];
      coreVecBusy = k[1];
      acc(1'b0, c15_regs_pkg::OP1_VBUSY, c15_regs_pkg::CRM_VBUSY, c15_regs_pkg::OP2_VBUSY, 32'h0, k[0], 1'b0,
          {31'h0, k[0] | k[1]}, 1'b0);
    end
    // Write attempt from both states, busy still tracks the pipelines
    acc(1'b1, c15_regs_pkg::OP1_VBUSY, c15_regs_pkg::CRM_VBUSY, c15_regs_pkg::OP2_VBUSY, 32'hffff_ffff, 1'b0,
        1'b0, 32'h0, 1'b0);
    acc(1'b1, c15_regs_pkg::OP1_VBUSY, c15_regs_pkg::CRM_VBUSY, c15_regs_pkg::OP2_VBUSY, 32'hffff_ffff, 1'b1,
        1'b0, 32'h0, 1'b0);
    vecPipeBusy = 1'b0;
    coreVecBusy = 1'b0;
    acc(1'b0, c15_regs_pkg::OP1_VBUSY, c15_regs_pkg::CRM_VBUSY, c15_regs_pkg::OP2_VBUSY, 32'h0, 1'b0, 1'b0,
        32'h0, 1'b0);
    $display("test busy done");
  endtask

  task automatic test_cfgbase();
    acc(1'b1, c15_regs_pkg::OP1_CFGBASE, c15_regs_pkg::CRM_CFGBASE, c15_regs_pkg::OP2_CFGBASE, 32'hc3c3_ffff,
        1'b0, 1'b0, 32'h0, 1'b0);
    chk({13'h0, cfgBaseOut}, 32'h0006_1e1f);
    acc(1'b1, c15_regs_pkg::OP1_CFGBASE, c15_regs_pkg::CRM_CFGBASE, c15_regs_pkg::OP2_CFGBASE, 32'h1111_2000,
        1'b1, 1'b0, 32'h0, 1'b0);
    acc(1'b1, c15_regs_pkg::OP1_CFGBASE, c15_regs_pkg::CRM_CFGBASE, c15_regs_pkg::OP2_CFGBASE, 32'h2222_4000,
        1'b0, 1'b1, 32'h0, 1'b0);
    acc(1'b0, c15_regs_pkg::OP1_CFGBASE, c15_regs_pkg::CRM_CFGBASE, c15_regs_pkg::OP2_CFGBASE, 32'h0,
        1'b1, 1'b0, 32'hc3c3_e000, 1'b0);
    chk({13'h0, cfgBaseOut}, 32'h0006_1e1f);
    $display("test base done");
  endtask

  task automatic test_lockdown();
    // Restore every entry, physical address last
    for (int i = 0; i < c15_regs_pkg::LOCK_ENTRIES; i++) begin
      acc(1'b1, c15_regs_pkg::OP1_LOCK, c15_regs_pkg::CRM_SELECT, c15_regs_pkg::OP2_SEL_WR, i, 1'b0, 1'b0,
          32'h0, 1'b0);
      acc(1'b1, c15_regs_pkg::OP1_LOCK, c15_regs_pkg::CRM_VTAG, c15_regs_pkg::OP2_LOCKDATA, vtPat(i), 1'b0, 1'b0,
          32'h0, 1'b0);
      acc(1'b1, c15_regs_pkg::OP1_LOCK, c15_regs_pkg::CRM_ATTR, c15_regs_pkg::OP2_LOCKDATA, atPat(i), 1'b0, 1'b0,
          32'h0, 1'b0);
      acc(1'b1, c15_regs_pkg::OP1_LOCK, c15_regs_pkg::CRM_PADDR, c15_regs_pkg::OP2_LOCKDATA, paPat(i), 1'b0, 1'b0,
          32'h0, 1'b0);
    end
    // Staged tag for entry 0 without a closing physical address write
    acc(1'b1, c15_regs_pkg::OP1_LOCK, c15_regs_pkg::CRM_SELECT, c15_regs_pkg::OP2_SEL_WR, 32'h0, 1'b0, 1'b0,
        32'h0, 1'b0);
    acc(1'b1, c15_regs_pkg::OP1_LOCK, c15_regs_pkg::CRM_VTAG, c15_regs_pkg::OP2_LOCKDATA, 32'h0, 1'b0, 1'b0,
        32'h0, 1'b0);
    // Save in reverse order so a stuck index shows
    for (int i = c15_regs_pkg::LOCK_ENTRIES - 1; i >= 0; i--) begin
      acc(1'b1, c15_regs_pkg::OP1_LOCK, c15_regs_pkg::CRM_SELECT, c15_regs_pkg::OP2_SEL_RD, i, 1'b0, 1'b0,
          32'h0, 1'b0);
      acc(1'b0, c15_regs_pkg::OP1_LOCK, c15_regs_pkg::CRM_VTAG, c15_regs_pkg::OP2_LOCKDATA, 32'h0, 1'b0, 1'b0,
          vtPat(i) & c15_regs_pkg::VTAG_WMASK, 1'b0);
      acc(1'b0, c15_regs_pkg::OP1_LOCK, c15_regs_pkg::CRM_ATTR, c15_regs_pkg::OP2_LOCKDATA, 32'h0, 1'b0, 1'b0,
          atPat(i), 1'b0);
      acc(1'b0, c15_regs_pkg::OP1_LOCK, c15_regs_pkg::CRM_PADDR, c15_regs_pkg::OP2_LOCKDATA, 32'h0, 1'b0, 1'b0,
          paPat(i), 1'b0);
    end
    $display("test lockdown done");
  endtask

  task automatic test_denied();
    acc(1'b1, c15_regs_pkg::OP1_LOCK, c15_regs_pkg::CRM_SELECT, c15_regs_pkg::OP2_SEL_WR, 32'h1, 1'b1, 1'b0,
        32'h0, 1'b1);
    acc(1'b1, c15_regs_pkg::OP1_LOCK, c15_regs_pkg::CRM_SELECT, c15_regs_pkg::OP2_SEL_RD, 32'h1, 1'b1, 1'b0,
        32'h0, 1'b1);
    acc(1'b0, c15_regs_pkg::OP1_LOCK, c15_regs_pkg::CRM_VTAG, c15_regs_pkg::OP2_LOCKDATA, 32'h0, 1'b1, 1'b0,
        32'h0, 1'b1);
    acc(1'b0, c15_regs_pkg::OP1_LOCK, c15_regs_pkg::CRM_PADDR, c15_regs_pkg::OP2_LOCKDATA, 32'h0, 1'b1, 1'b0,
        32'h0, 1'b1);
    // Select is write-only even from Secure privileged code
    acc(1'b0, c15_regs_pkg::OP1_LOCK, c15_regs_pkg::CRM_SELECT, c15_regs_pkg::OP2_SEL_RD, 32'h0, 1'b0, 1'b0,
        32'h0, 1'b1);
    // Attribute read of entry 0 stays open to Non-secure privileged code
    acc(1'b0, c15_regs_pkg::OP1_LOCK, c15_regs_pkg::CRM_ATTR, c15_regs_pkg::OP2_LOCKDATA, 32'h0, 1'b1, 1'b0,
        atPat(0), 1'b0);
    acc(1'b0, c15_regs_pkg::OP1_LOCK, c15_regs_pkg::CRM_ATTR, c15_regs_pkg::OP2_LOCKDATA, 32'h0, 1'b0, 1'b1,
        32'h0, 1'b1);
    acc(1'b0, 3'h7, 4'h3, 3'h5, 32'h0, 1'b0, 1'b0, 32'h0, 1'b1);
    $display("test denied done");
  endtask

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    errors = 0;
    n_tests = 0;
    rst_b = 1'b0;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqOp1 = 3'h0;
    reqCrn = c15_regs_pkg::CRN_C15;
    reqCrm = 4'h0;
    reqOp2 = 3'h0;
    reqWdata = 32'h0;
    nonsecure = 1'b0;
    userMode = 1'b0;
    vecPipeBusy = 1'b0;
    coreVecBusy = 1'b0;
    peripheralBaseStrap = 19'h5a5a5;
    repeat (5) @(negedge mclk);
    rst_b = 1'b1;
    // Strap phase and synchroniser settle before the first request
    repeat (6) @(negedge mclk);
    test_reset();
    test_busy();
    test_cfgbase();
    test_lockdown();
    test_denied();
    results();
  end

  // About 54 transfers of two cycles each; generous margin
  initial begin
    #5000;
    errors++;
    results();
  end
endmodule
`default_nettype wire
